/* pktz_pkg.sv */
// Constants, configuration layout and factory values of the packetizer.
// Assumes a 100 MHz system clock; all timing counts derive from CLK_HZ.
package pktz_pkg;
  // Clock and serial rate limits, divisor kept in 1/16 cycle units
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned FRAC = 16;
  localparam int unsigned BAUD_MIN = 300;
  localparam int unsigned BAUD_MAX = 921_600;
  localparam int unsigned BAUD_DEF = 9_600;
  localparam logic [23:0] DIV_MIN = 24'(CLK_HZ * FRAC / BAUD_MAX);
  localparam logic [23:0] DIV_MAX = 24'(CLK_HZ * FRAC / BAUD_MIN);
  localparam logic [23:0] DIV_DEF = 24'(CLK_HZ * FRAC / BAUD_DEF);
  // Idle timeout unit and hardware idle detector
  localparam int unsigned UNIT_MS = 5;
  localparam int unsigned UNIT_CYC = CLK_HZ / 1000 * UNIT_MS;
  localparam logic [7:0] TMO_MAX = 8'hc8;
  localparam logic [2:0] IDLE_CHARS = 3'h4;
  // Packet length and buffer
  localparam logic [10:0] PKT_MIN = 11'h001;
  localparam logic [10:0] PKT_MAX = 11'h400;
  localparam logic [10:0] PKT_DEF = 11'h400;
  localparam int unsigned BUF_DEPTH = 1024;
  localparam int unsigned NAME_WORDS = 5;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0c;
  localparam logic [7:0] OFS_FRAME = 8'h10;
  localparam logic [7:0] OFS_PKTLEN = 8'h14;
  localparam logic [7:0] OFS_TMO = 8'h18;
  localparam logic [7:0] OFS_LIP = 8'h1c;
  localparam logic [7:0] OFS_MASK = 8'h20;
  localparam logic [7:0] OFS_GW = 8'h24;
  localparam logic [7:0] OFS_DIP = 8'h28;
  localparam logic [7:0] OFS_PORTS = 8'h2c;
  localparam logic [7:0] OFS_RETRY = 8'h30;
  localparam logic [7:0] OFS_NAME0 = 8'h34;
  localparam logic [7:0] OFS_NAME4 = 8'h44;
  // Control bits
  localparam int unsigned CTRL_SAVE = 0;
  localparam int unsigned CTRL_DEFAULTS = 1;
  // Network modes and parity codes
  localparam logic [1:0] NM_TCP_SERVER = 2'h0;
  localparam logic [1:0] NM_TCP_CLIENT = 2'h1;
  localparam logic [2:0] PAR_NONE = 3'h0;
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_EVEN = 3'h2;
  localparam logic [2:0] PAR_ZERO = 3'h3;
  localparam logic [2:0] PAR_ONE = 3'h4;

  typedef struct packed {
    logic [1:0] nmode;      // Port 1 network mode
    logic port2_en;
    logic dhcp_en;
    logic neg_en;           // Serial negotiation into config mode
    logic close_on_loss;
    logic clear_pre;        // Discard bytes before connection
    logic dest_is_name;     // Destination given as domain name
    logic [23:0] div;
    logic [1:0] dbits;      // Data bits minus five
    logic two_stop;
    logic [2:0] parity;
    logic [10:0] pktlen;
    logic [7:0] tmo;
    logic [31:0] lip;
    logic [31:0] mask;
    logic [31:0] gw;
    logic [31:0] dip;
    logic [15:0] lport;
    logic [15:0] dport;
    logic [7:0] retry;      // Zero means unlimited
    logic [NAME_WORDS-1:0][31:0] name;
  } cfg_s;

  localparam cfg_s CFG_DEFAULT = '{
    nmode: NM_TCP_CLIENT, port2_en: 1'b0, dhcp_en: 1'b0, neg_en: 1'b0,
    close_on_loss: 1'b0, clear_pre: 1'b0, dest_is_name: 1'b0,
    div: DIV_DEF, dbits: 2'h3, two_stop: 1'b0, parity: PAR_NONE,
    pktlen: PKT_DEF, tmo: 8'h00,
    lip: 32'hc0a801c8, mask: 32'hffffff00, gw: 32'hc0a80101,
    dip: 32'hc0a80164, lport: 16'h07d0, dport: 16'h03e8,
    retry: 8'h00, name: '0};

  typedef enum {U_IDLE, U_START, U_DATA, U_PAR, U_STOP, U_STOP2} uart_e;
endpackage

/* uart_net_packetizer.sv */
// Serial-to-network packetizer with APB configuration and serial framer.
// Assumes all inputs synchronous to CLK; the network stack consumes the
// payload stream and reports link and connection state.
// What this block does
// - Stored configuration reloads after every reset without FACTORY_LOAD
// - Module name limited to twenty bytes
// - Address from DHCP or manual, selectable
// - Serial negotiation mode off unless enabled
// - Bit rate configurable 300 to 921600
// - Accurate transmit rate, tolerant mid-bit receive
// - Five to eight bits, stops, five parities
// - Link loss closes connection or nothing
// - Threshold 1 to 1024 sends immediately
// - Idle timeout 0 to 200 units, 5ms
// - Timeout sends everything buffered so far
// - Zero timeout uses four character times
// - Pre-connection bytes discarded or kept, configurable
// - Destination as IP or domain name
// - Defaults: port 2 off, TCP client
// - Default local, mask and gateway addresses
// - Default ports and destination address
// - Reconnect attempts unlimited by default
// - Serial defaults 9600, 8N1, never clear
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
module uart_net_packetizer
  import pktz_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = UNIT_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  input wire logic FACTORY_LOAD,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Serial pins
  input wire logic RXD,
  output logic TXD,
  // Network status
  input wire logic LINK_UP,
  input wire logic CONN_UP,
  output logic CONN_CLOSE,
  // Payload towards the network
  output logic PL_VALID,
  output logic [7:0] PL_DATA,
  output logic PL_LAST,
  input wire logic PL_READY,
  // Data from the network to the serial line
  input wire logic NET_VALID,
  input wire logic [7:0] NET_DATA,
  output logic NET_READY,
  // Configuration exported to the stack
  output logic DHCP_EN,
  output logic NEG_EN,
  output logic [1:0] PORT1_MODE,
  output logic PORT2_EN,
  output logic DEST_IS_NAME
);
  typedef struct packed {
    cfg_s cfg;
    cfg_s store;          // Survives SRST unless FACTORY_LOAD, the non-volatile copy
    logic [31:0] prdata;
    uart_e rx_st;
    logic [23:0] rx_acc;
    logic [2:0] rx_bit;
    logic [7:0] rx_data;
    logic par_err;
    logic frm_err;
    uart_e tx_st;
    logic [23:0] tx_acc;
    logic [2:0] tx_bit;
    logic [7:0] tx_data;
    logic txd;
    logic [9:0] wr_ptr;
    logic [9:0] rd_ptr;
    logic [10:0] total;
    logic [10:0] pending;
    logic [10:0] send_left;
    logic ovf;
    logic [23:0] idle_cyc;
    logic [7:0] idle_units;
    logic [5:0] idle_bits;
    logic idle_exp;
    logic pl_valid;
    logic [7:0] pl_data;
    logic pl_last;
    logic link_prev;
    logic close;
  } st_s;

  st_s q;
  st_s d;
  logic [7:0] mem [BUF_DEPTH];
  logic mem_we;
  logic [24:0] tx_sum;
  logic [24:0] rx_sum;
  logic tx_tick;
  logic rx_tick;
  logic rx_done;
  logic rx_keep;
  logic [2:0] nbits;
  logic [5:0] char_bits;
  logic fire_th;
  logic fire_to;
  logic wr_en;
  logic [2:0] nidx;
  logic [10:0] sent;
  logic ld;

  // Expected parity bit for a masked data word
  function automatic logic par_bit(input logic [2:0] mode,
                                   input logic [7:0] data);
    unique case (mode)
      PAR_ODD: par_bit = ~^data;
      PAR_EVEN: par_bit = ^data;
      PAR_ONE: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction

  // Register read view
  function automatic logic [31:0] rd_word(input logic [7:0] a,
                                          input st_s s);
    logic [2:0] ni;
    ni = 3'((a - OFS_NAME0) >> 2);
    rd_word = 32'h0;
    if (a >= OFS_NAME0 && a <= OFS_NAME4) begin
      rd_word = s.cfg.name[ni];
    end else begin
      case (a)
        OFS_STATUS: rd_word = {5'h0, s.total, s.pending, CONN_UP,
                               LINK_UP, s.frm_err, s.par_err, s.ovf};
        OFS_MODE: rd_word = {24'h0, s.cfg.dest_is_name, s.cfg.clear_pre,
                             s.cfg.close_on_loss, s.cfg.neg_en,
                             s.cfg.dhcp_en, s.cfg.port2_en, s.cfg.nmode};
        OFS_BAUD: rd_word = {8'h0, s.cfg.div};
        OFS_FRAME: rd_word = {26'h0, s.cfg.parity, s.cfg.two_stop,
                              s.cfg.dbits};
        OFS_PKTLEN: rd_word = {21'h0, s.cfg.pktlen};
        OFS_TMO: rd_word = {24'h0, s.cfg.tmo};
        OFS_LIP: rd_word = s.cfg.lip;
        OFS_MASK: rd_word = s.cfg.mask;
        OFS_GW: rd_word = s.cfg.gw;
        OFS_DIP: rd_word = s.cfg.dip;
        OFS_PORTS: rd_word = {s.cfg.dport, s.cfg.lport};
        OFS_RETRY: rd_word = {24'h0, s.cfg.retry};
        default: rd_word = 32'h0;
      endcase
    end
  endfunction

  // Address decode for error answers
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= OFS_NAME4);
  endfunction

  // Next-state logic
  always_comb begin
    d = q;
    d.close = 1'b0;
    mem_we = 1'b0;
    rx_done = 1'b0;
    nbits = 3'(q.cfg.dbits) + 3'h4;
    char_bits = 6'h3 + 6'(q.cfg.dbits) + 6'h5 +
                6'(q.cfg.parity != PAR_NONE) + 6'(q.cfg.two_stop) - 6'h1;
    wr_en = PSEL && PENABLE && PWRITE && mapped(PADDR);
    nidx = 3'((PADDR - OFS_NAME0) >> 2);

    // Fractional bit timers keep the mean rate exact
    tx_sum = {1'b0, q.tx_acc} + 25'(FRAC);
    tx_tick = tx_sum >= {1'b0, q.cfg.div};
    d.tx_acc = tx_tick ? 24'(tx_sum - {1'b0, q.cfg.div}) : tx_sum[23:0];
    rx_sum = {1'b0, q.rx_acc} + 25'(FRAC);
    rx_tick = rx_sum >= {1'b0, q.cfg.div};
    d.rx_acc = rx_tick ? 24'(rx_sum - {1'b0, q.cfg.div}) : rx_sum[23:0];

    // APB read capture in the setup phase
    if (PSEL && !PENABLE && !PWRITE) begin
      d.prdata = rd_word(PADDR, q);
    end

    // APB writes, range limited on entry
    if (wr_en) begin
      if (PADDR >= OFS_NAME0) begin
        d.cfg.name[nidx] = PWDATA;
      end else begin
        case (PADDR)
          OFS_CTRL: begin
            if (PWDATA[CTRL_SAVE]) d.store = q.cfg;
            if (PWDATA[CTRL_DEFAULTS]) d.cfg = CFG_DEFAULT;
          end
          OFS_STATUS: begin
            // Write one to clear error flags
            if (PWDATA[0]) d.ovf = 1'b0;
            if (PWDATA[1]) d.par_err = 1'b0;
            if (PWDATA[2]) d.frm_err = 1'b0;
          end
          OFS_MODE: begin
            d.cfg.nmode = PWDATA[1:0];
            d.cfg.port2_en = PWDATA[2];
            d.cfg.dhcp_en = PWDATA[3];
            d.cfg.neg_en = PWDATA[4];
            d.cfg.close_on_loss = PWDATA[5];
            d.cfg.clear_pre = PWDATA[6];
            d.cfg.dest_is_name = PWDATA[7];
          end
          OFS_BAUD: begin
            if (PWDATA[23:0] < DIV_MIN) d.cfg.div = DIV_MIN;
            else if (PWDATA[23:0] > DIV_MAX) d.cfg.div = DIV_MAX;
            else d.cfg.div = PWDATA[23:0];
          end
          OFS_FRAME: begin
            d.cfg.dbits = PWDATA[1:0];
            d.cfg.two_stop = PWDATA[2];
            d.cfg.parity = (PWDATA[5:3] > PAR_ONE) ? PAR_NONE : PWDATA[5:3];
          end
          OFS_PKTLEN: begin
            if (PWDATA[31:0] < 32'(PKT_MIN)) d.cfg.pktlen = PKT_MIN;
            else if (PWDATA[31:0] > 32'(PKT_MAX)) d.cfg.pktlen = PKT_MAX;
            else d.cfg.pktlen = PWDATA[10:0];
          end
          OFS_TMO: begin
            if (PWDATA[31:0] > 32'(TMO_MAX)) d.cfg.tmo = TMO_MAX;
            else d.cfg.tmo = PWDATA[7:0];
          end
          OFS_LIP: d.cfg.lip = PWDATA;
          OFS_MASK: d.cfg.mask = PWDATA;
          OFS_GW: d.cfg.gw = PWDATA;
          OFS_DIP: d.cfg.dip = PWDATA;
          OFS_PORTS: {d.cfg.dport, d.cfg.lport} = PWDATA;
          OFS_RETRY: d.cfg.retry = PWDATA[7:0];
          default: d.cfg.retry = q.cfg.retry;
        endcase
      end
    end

    // Receiver, sampled mid-bit from the start edge
    unique case (q.rx_st)
      U_IDLE: begin
        d.rx_acc = q.cfg.div >> 1;
        if (!RXD) begin
          d.rx_st = U_START;
          d.rx_data = 8'h00;
          d.rx_bit = 3'h0;
        end
      end
      U_START: if (rx_tick) d.rx_st = RXD ? U_IDLE : U_DATA;
      U_DATA: if (rx_tick) begin
        d.rx_data[q.rx_bit] = RXD;
        d.rx_bit = q.rx_bit + 3'h1;
        if (q.rx_bit == nbits) begin
          d.rx_st = (q.cfg.parity == PAR_NONE) ? U_STOP : U_PAR;
        end
      end
      U_PAR: if (rx_tick) begin
        if (RXD != par_bit(q.cfg.parity, q.rx_data)) d.par_err = 1'b1;
        d.rx_st = U_STOP;
      end
      U_STOP, U_STOP2: if (rx_tick) begin
        d.rx_st = U_IDLE;
        if (RXD) rx_done = 1'b1;
        else d.frm_err = 1'b1;
      end
    endcase

    // Transmitter, network bytes onto the serial line
    NET_READY = (q.tx_st == U_IDLE);
    unique case (q.tx_st)
      U_IDLE: begin
        d.txd = 1'b1;
        if (NET_VALID) begin
          d.tx_st = U_START;
          d.tx_acc = 24'h0;
          d.txd = 1'b0;
          d.tx_bit = 3'h0;
          d.tx_data = NET_DATA & (8'hff >> (3'h3 - 3'(q.cfg.dbits)));
        end
      end
      U_START: if (tx_tick) begin
        d.tx_st = U_DATA;
        d.txd = q.tx_data[0];
      end
      U_DATA: if (tx_tick) begin
        d.tx_bit = q.tx_bit + 3'h1;
        d.txd = q.tx_data[q.tx_bit + 3'h1];
        if (q.tx_bit == nbits) begin
          d.tx_st = (q.cfg.parity == PAR_NONE) ? U_STOP : U_PAR;
          d.txd = (q.cfg.parity == PAR_NONE) ? 1'b1 :
                  par_bit(q.cfg.parity, q.tx_data);
        end
      end
      U_PAR: if (tx_tick) begin
        d.tx_st = U_STOP;
        d.txd = 1'b1;
      end
      U_STOP: if (tx_tick) d.tx_st = q.cfg.two_stop ? U_STOP2 : U_IDLE;
      U_STOP2: if (tx_tick) d.tx_st = U_IDLE;
    endcase

    // Buffer byte before connection: keep or discard
    rx_keep = rx_done && !(q.cfg.clear_pre && !CONN_UP);
    if (rx_keep && q.total == PKT_MAX) begin
      rx_keep = 1'b0;
      d.ovf = 1'b1;
    end
    if (rx_keep) begin
      mem_we = 1'b1;
      d.wr_ptr = q.wr_ptr + 10'h1;
    end

    // Idle timing, restarted by every byte
    if (rx_done) begin
      d.idle_cyc = 24'h0;
      d.idle_units = 8'h0;
      d.idle_bits = 6'h0;
      d.idle_exp = 1'b0;
    end else if (!q.idle_exp) begin
      if (q.cfg.tmo == 8'h00) begin
        if (tx_tick) begin
          d.idle_bits = q.idle_bits + 6'h1;
          // Four character times of silence
          if (d.idle_bits >= 6'(char_bits * 6'(IDLE_CHARS)))
            d.idle_exp = 1'b1;
        end
      end else if (q.idle_cyc == 24'(UNIT_CYCLES - 1)) begin
        d.idle_cyc = 24'h0;
        d.idle_units = q.idle_units + 8'h1;
        if (d.idle_units >= q.cfg.tmo) d.idle_exp = 1'b1;
      end else begin
        d.idle_cyc = q.idle_cyc + 24'h1;
      end
    end

    // Packet triggers, only while connected and not draining
    fire_th = CONN_UP && q.send_left == 11'h0 &&
              q.pending >= q.cfg.pktlen;
    fire_to = CONN_UP && q.send_left == 11'h0 && !fire_th &&
              q.idle_exp && q.pending != 11'h0;
    sent = fire_th ? q.cfg.pktlen : (fire_to ? q.pending : 11'h0);
    d.pending = q.pending + 11'(rx_keep) - sent;
    if (fire_th || fire_to) begin
      d.send_left = sent;
      // Fresh count and fresh idle timing after each send
      d.idle_cyc = 24'h0;
      d.idle_units = 8'h0;
      d.idle_bits = 6'h0;
      d.idle_exp = 1'b0;
    end

    // Payload output stage
    ld = (!q.pl_valid || PL_READY) && q.send_left != 11'h0;
    if (!q.pl_valid || PL_READY) d.pl_valid = ld;
    if (ld) begin
      d.pl_data = mem[q.rd_ptr];
      d.pl_last = (q.send_left == 11'h1);
      d.rd_ptr = q.rd_ptr + 10'h1;
      d.send_left = q.send_left - 11'h1;
    end
    d.total = q.total + 11'(rx_keep) - 11'(ld);

    // Cable loss handling
    d.link_prev = LINK_UP;
    if (q.link_prev && !LINK_UP && q.cfg.close_on_loss) d.close = 1'b1;

    // Reset reloads stored values, or factory values when asked
    if (SRST) begin
      d = '0;
      d.rx_st = U_IDLE;
      d.tx_st = U_IDLE;
      d.txd = 1'b1;
      d.link_prev = 1'b0;
      d.store = FACTORY_LOAD ? CFG_DEFAULT : q.store;
      d.cfg = FACTORY_LOAD ? CFG_DEFAULT : q.store;
      // Defaults hold retry 0 as unlimited, 9600 8N1
    end
  end

  // State register
  always_ff @(posedge CLK) begin
    q <= d;
  end

  // Payload buffer
  always_ff @(posedge CLK) begin
    if (mem_we) begin
      mem[q.wr_ptr] <= q.rx_data;
    end
  end

  // Outputs
  assign PRDATA = q.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped(PADDR);
  assign TXD = q.txd;
  assign CONN_CLOSE = q.close;
  assign PL_VALID = q.pl_valid;
  assign PL_DATA = q.pl_data;
  assign PL_LAST = q.pl_last;
  assign DHCP_EN = q.cfg.dhcp_en;
  assign NEG_EN = q.cfg.neg_en;
  assign PORT1_MODE = q.cfg.nmode;
  assign PORT2_EN = q.cfg.port2_en;
  assign DEST_IS_NAME = q.cfg.dest_is_name;

  // Checks
  property p_store_reload;
    @(posedge CLK) disable iff (SRST)
    $fell(SRST) && !$past(FACTORY_LOAD) |-> q.cfg == q.store;
  endproperty
  a_store_reload: assert property (p_store_reload)
    else $error("config not reloaded from store");

  property p_div_range;
    @(posedge CLK) disable iff (SRST)
    q.cfg.div >= DIV_MIN && q.cfg.div <= DIV_MAX;
  endproperty
  a_div_range: assert property (p_div_range)
    else $error("bit rate divisor out of range");

  property p_close;
    @(posedge CLK) disable iff (SRST)
    $fell(LINK_UP) && q.cfg.close_on_loss |=> CONN_CLOSE ##1 !CONN_CLOSE;
  endproperty
  a_close: assert property (p_close)
    else $error("no close pulse on link loss");

  property p_thresh;
    @(posedge CLK) disable iff (SRST)
    fire_th |=> q.send_left == $past(q.cfg.pktlen);
  endproperty
  a_thresh: assert property (p_thresh)
    else $error("threshold send length wrong");

  property p_tmo_range;
    @(posedge CLK) disable iff (SRST)
    q.cfg.tmo <= TMO_MAX && q.cfg.pktlen >= PKT_MIN;
  endproperty
  a_tmo_range: assert property (p_tmo_range)
    else $error("timeout or length setting out of range");

  property p_flush;
    @(posedge CLK) disable iff (SRST)
    fire_to |=> q.send_left == $past(q.pending);
  endproperty
  a_flush: assert property (p_flush)
    else $error("timeout did not send all buffered bytes");

  property p_preconn;
    @(posedge CLK) disable iff (SRST)
    rx_done && !CONN_UP && q.cfg.clear_pre |=> q.pending == $past(q.pending);
  endproperty
  a_preconn: assert property (p_preconn)
    else $error("byte kept although clearing is set");

  property p_restart;
    @(posedge CLK) disable iff (SRST)
    fire_th || fire_to |=> !q.idle_exp && q.pending <= 11'h1 +
      ($past(q.pending) - $past(sent));
  endproperty
  a_restart: assert property (p_restart)
    else $error("count or idle timing not restarted");

  property p_tx_start;
    @(posedge CLK) disable iff (SRST)
    NET_VALID && NET_READY |=> !TXD;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("start bit missing");
endmodule

/* pktz_peer.sv */
// Far side: serial host on the receive pin and payload sink.
// Assumes CLK at 100 MHz and a bit time of 108.5 cycles.
`timescale 1ns/1ps
module pktz_peer (
  // Clock
  input wire logic clk,
  // Serial host
  output logic rxd,
  // Payload sink
  input wire logic pl_valid,
  input wire logic [7:0] pl_data,
  input wire logic pl_last,
  output logic pl_ready
);
  logic [8:0] q[$];
  logic [1:0] ph;
  initial begin
    rxd = 1'b1;
    pl_ready = 1'b0;
    ph = 2'h0;
  end
  // Sink stalls one cycle in four, keeps bytes with their last flag
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    pl_ready <= (ph != 2'h3);
    if (pl_valid && pl_ready) begin
      q.push_back({pl_last, pl_data});
    end
  end
  // One 8N1 character, low bit first, 108 or 109 cycles a bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (108 + i % 2) @(posedge clk);
    end
  endtask
endmodule

/* tb_uart_net_packetizer.sv */
// Testbench: registers, packet triggers, idle rules, serial output.
// Assumes pktz_peer as serial host and sink; UNIT_CYCLES set to 500,
// so three timeout units outlast one character at the fastest rate.
`timescale 1ns/1ps
module tb_uart_net_packetizer;
  import pktz_pkg::*;
  logic CLK = 1'b0;
  logic SRST;
  logic FACTORY_LOAD;
  logic PSEL;
  logic PENABLE;
  logic PWRITE;
  logic [7:0] PADDR;
  logic [31:0] PWDATA;
  logic LINK_UP;
  logic CONN_UP;
  logic NET_VALID;
  logic [7:0] NET_DATA;
  logic [31:0] PRDATA;
  logic [7:0] PL_DATA;
  logic [1:0] PORT1_MODE;
  logic PREADY, PSLVERR, RXD, TXD, CONN_CLOSE, PL_VALID, PL_LAST, PL_READY;
  logic NET_READY, DHCP_EN, NEG_EN, PORT2_EN, DEST_IS_NAME;
  logic [5:0] cfg_o;
  logic [31:0] rd;
  logic er;
  int fails = 0;
  int check_count = 0;
  int t;

  uart_net_packetizer #(.UNIT_CYCLES(500)) uart_net_packetizer_i (
    .CLK, .SRST, .FACTORY_LOAD, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .RXD, .TXD, .LINK_UP, .CONN_UP, .CONN_CLOSE,
    .PL_VALID, .PL_DATA, .PL_LAST, .PL_READY, .NET_VALID, .NET_DATA,
    .NET_READY, .DHCP_EN, .NEG_EN, .PORT1_MODE, .PORT2_EN, .DEST_IS_NAME);
  pktz_peer pktz_peer_i (.clk(CLK), .rxd(RXD), .pl_valid(PL_VALID),
    .pl_data(PL_DATA), .pl_last(PL_LAST), .pl_ready(PL_READY));

  // Clock and exported config levels
  always #5 CLK = ~CLK;
  assign cfg_o = {DHCP_EN, NEG_EN, PORT2_EN, DEST_IS_NAME, PORT1_MODE};

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer, held until pready at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  task automatic rst(input logic fl);
    SRST <= 1'b1;
    FACTORY_LOAD <= fl;
    repeat (20) @(posedge CLK);
    SRST <= 1'b0;
    FACTORY_LOAD <= 1'b0;
  endtask

  // Waits, bounded, for n bytes at the sink; t holds the cycles taken
  task automatic pkt(input int n);
    t = 0;
    while (pktz_peer_i.q.size() < n && t < 20000) begin
      @(posedge CLK);
      t++;
    end
  endtask

  task automatic byt(input logic [8:0] e);
    chk("payload", 32'(e), 32'(pktz_peer_i.q.pop_front()));
  endtask

  task automatic t_defaults;
    rdchk("mode", OFS_MODE, 32'h1);
    rdchk("baud", OFS_BAUD, 32'h28b0a);
    rdchk("frame", OFS_FRAME, 32'h3);
    rdchk("tmo", OFS_TMO, 32'h0);
    rdchk("lip", OFS_LIP, 32'hc0a801c8);
    rdchk("mask", OFS_MASK, 32'hffffff00);
    rdchk("gw", OFS_GW, 32'hc0a80101);
    rdchk("dip", OFS_DIP, 32'hc0a80164);
    rdchk("ports", OFS_PORTS, 32'h03e807d0);
    rdchk("retry", OFS_RETRY, 32'h0);
    chk("cfg_out", 32'h1, 32'(cfg_o));
    $display("t_defaults done");
  endtask

  task automatic t_cfg;
    apb(1'b1, OFS_MODE, 32'h9e);
    @(posedge CLK);
    chk("cfg_set", 32'h3e, 32'(cfg_o));
    $display("t_cfg done");
  endtask

  task automatic t_store;
    apb(1'b1, OFS_LIP, 32'h0a000001);
    apb(1'b1, OFS_CTRL, 32'h1);
    rst(1'b0);
    rdchk("lip_kept", OFS_LIP, 32'h0a000001);
    apb(1'b1, OFS_NAME4, 32'h44434241);
    rdchk("name_end", OFS_NAME4, 32'h44434241);
    apb(1'b0, 8'h48, 32'h0);
    chk("past_name_err", 32'h1, 32'(er));
    chk("past_name_rd", 32'h0, rd);
    apb(1'b1, OFS_CTRL, 32'h2);
    rdchk("lip_factory", OFS_LIP, 32'hc0a801c8);
    $display("t_store done");
  endtask

  task automatic t_thresh;
    apb(1'b1, OFS_BAUD, 32'h6c8);
    apb(1'b1, OFS_PKTLEN, 32'h3);
    CONN_UP <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      pktz_peer_i.send(8'ha0 + 8'(i));
    end
    chk("thresh_count", 32'h3, 32'(pktz_peer_i.q.size()));
    pkt(4);
    chk("idle4_gap", 32'h1, 32'(t > 3700 && t < 4800));
    for (int i = 0; i < 4; i++) begin
      byt({1'(i >= 2), 8'ha0 + 8'(i)});
    end
    $display("t_thresh done");
  endtask

  task automatic t_tmo;
    apb(1'b1, OFS_TMO, 32'h3);
    apb(1'b1, OFS_PKTLEN, 32'ha);
    pktz_peer_i.send(8'hc1);
    pktz_peer_i.send(8'hc2);
    pkt(2);
    chk("tmo_gap", 32'h1, 32'(t > 1300 && t < 1700));
    byt(9'h0c1);
    byt(9'h1c2);
    $display("t_tmo done");
  endtask

  task automatic t_pre;
    CONN_UP <= 1'b0;
    apb(1'b1, OFS_MODE, 32'h41);
    pktz_peer_i.send(8'h11);
    rdchk("pend_drop", OFS_STATUS, 32'h8);
    chk("pend_drop_n", 32'h0, rd & 32'hffe0);
    apb(1'b1, OFS_MODE, 32'h1);
    pktz_peer_i.send(8'h5a);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("pend_keep", 32'h20, rd & 32'hffe0);
    CONN_UP <= 1'b1;
    pkt(1);
    byt(9'h15a);
    $display("t_pre done");
  endtask

  task automatic t_link;
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, OFS_MODE, k ? 32'h1 : 32'h21);
      LINK_UP <= 1'b0;
      t = 0;
      repeat (4) begin
        @(posedge CLK);
        t += int'(CONN_CLOSE === 1'b1);
      end
      chk("close_pulses", k ? 32'h0 : 32'h1, 32'(t));
      LINK_UP <= 1'b1;
    end
    $display("t_link done");
  endtask

  // Sends one byte in the given frame and samples TXD mid-bit
  task automatic t_tx(input logic [2:0] p, input logic [7:0] d);
    logic e[$];
    logic par;
    int n;
    n = 5 + int'(p[1:0]);
    par = ^(d & 8'((9'h1 << n) - 9'h1));
    apb(1'b1, OFS_FRAME, {26'h0, p, p[0], p[1:0]});
    e.push_back(1'b0);
    for (int i = 0; i < n; i++) begin
      e.push_back(d[i]);
    end
    if (p != PAR_NONE) begin
      e.push_back(p == PAR_ODD ? ~par : p == PAR_EVEN ? par : p == PAR_ONE);
    end
    e.push_back(1'b1);
    NET_DATA <= d;
    NET_VALID <= 1'b1;
    do @(posedge CLK); while (NET_READY !== 1'b1);
    NET_VALID <= 1'b0;
    repeat (54) @(posedge CLK);
    foreach (e[i]) begin
      chk("txd", 32'(e[i]), 32'(TXD));
      repeat (108 + i % 2) @(posedge CLK);
    end
    $display("t_tx done");
  endtask

  // Main sequence
  initial begin
    // Idle bus and link levels before the first reset
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    PWRITE <= 1'b0;
    PADDR <= 8'h00;
    PWDATA <= 32'h0;
    LINK_UP <= 1'b1;
    CONN_UP <= 1'b0;
    NET_VALID <= 1'b0;
    NET_DATA <= 8'h00;
    rst(1'b1);
    t_defaults;
    t_cfg;
    t_store;
    t_thresh;
    t_tmo;
    t_pre;
    t_link;
    for (int p = 0; p < 5; p++) begin
      t_tx(3'(p), 8'hb5 ^ 8'(p * 8'h3c));
    end
    report_and_stop;
  end

  // Watchdog well past the expected run
  initial begin
    repeat (60000) @(posedge CLK);
    fails++;
    report_and_stop;
  end
endmodule
